// [logic/ubcsd_pkg.sv]
// constants for the utility-bus chip select decode block
package ubcsd_pkg;
  localparam logic [15:0] ADDR_ALT_SYS_CTRL = 16'h0092;
  localparam logic [15:0] ADDR_FPU_CLEAR = 16'h00f0;
  localparam logic [15:0] ADDR_DECODE_ENABLE = 16'h0040;
  localparam logic [15:0] ADDR_DECODE_SELECT = 16'h0041;
  localparam logic [15:0] ADDR_ISA_CLOCK_DIV = 16'h004d;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int ALT_RESET_BIT = 0;
  localparam int ALTERNATE_GATE_A20_BIT = 1;
  localparam int FPU_MODE_BIT = 5;
  localparam int EN_FLOPPY_BIT = 0;
  localparam int EN_DISK_BIT = 1;
  localparam int EN_SECONDARY_BIT = 2;
  localparam int EN_BIOS_LOW_BIT = 3;
  localparam int EN_BIOS_EXT_BIT = 4;
  localparam int EN_SERIAL_A_BIT = 5;
  localparam int EN_SERIAL_B_BIT = 6;
  localparam int EN_PRINTER_BIT = 7;
  localparam int SEL_SERIAL_A_BIT = 0;
  localparam int SEL_SERIAL_B_BIT = 1;
  localparam int SEL_PRINTER_LSB = 2;
  localparam logic [1:0] PRN_RANGE1 = 2'h0;
  localparam logic [1:0] PRN_RANGE2 = 2'h1;
  localparam logic [1:0] PRN_RANGE3 = 2'h2;
  localparam logic [3:0] SEL_IDLE = 4'hf;
  localparam logic [3:0] SEL_CLOCK_STROBE = 4'h0;
  localparam logic [3:0] SEL_CLOCK_CHIP = 4'h1;
  localparam logic [3:0] SEL_KEYBOARD = 4'h2;
  localparam logic [3:0] SEL_BOOT_ROM = 4'h3;
  localparam logic [3:0] SEL_FLOPPY = 4'h4;
  localparam logic [3:0] SEL_DISK0 = 4'h5;
  localparam logic [3:0] SEL_DISK1 = 4'h6;
  localparam logic [3:0] SEL_CONFIG_PAGE = 4'h9;
  localparam logic [3:0] SEL_CONFIG_MEM = 4'ha;
  localparam logic [3:0] SEL_SERIAL_A = 4'hb;
  localparam logic [3:0] SEL_SERIAL_B = 4'hc;
  localparam logic [3:0] SEL_PRINTER = 4'hd;
  localparam logic [15:0] IO_CLOCK_LO = 16'h0070;
  localparam logic [15:0] IO_CLOCK_HI = 16'h0077;
  localparam logic [15:0] IO_KBD_A = 16'h0060;
  localparam logic [15:0] IO_KBD_B = 16'h0062;
  localparam logic [15:0] IO_KBD_C = 16'h0064;
  localparam logic [15:0] IO_KBD_D = 16'h0066;
  localparam logic [15:0] IO_FLOPPY_PRI = 16'h03f0;
  localparam logic [15:0] IO_FLOPPY_SEC = 16'h0370;
  localparam logic [15:0] IO_DISK0_PRI = 16'h01f0;
  localparam logic [15:0] IO_DISK0_SEC = 16'h0170;
  localparam logic [15:0] IO_DISK1_PRI = 16'h03f6;
  localparam logic [15:0] IO_DISK1_SEC = 16'h0376;
  localparam logic [15:0] IO_DISK_CHANGE_PRI = 16'h03f7;
  localparam logic [15:0] IO_DISK_CHANGE_SEC = 16'h0377;
  localparam logic [15:0] IO_CONFIG_PAGE = 16'h0c00;
  localparam logic [15:0] IO_CONFIG_MEM = 16'h0800;
  localparam logic [15:0] IO_SERIAL_1 = 16'h03f8;
  localparam logic [15:0] IO_SERIAL_2 = 16'h02f8;
  localparam logic [15:0] IO_PRINTER_1 = 16'h03bc;
  localparam logic [15:0] IO_PRINTER_2 = 16'h0378;
  localparam logic [15:0] IO_PRINTER_3 = 16'h0278;
  localparam logic [15:0] IO_FPU_CLEAR = 16'h00f0;
  localparam logic [15:0] SPAN_8 = 16'h0007;
  localparam logic [15:0] SPAN_4 = 16'h0003;
  localparam logic [15:0] SPAN_2 = 16'h0001;
  localparam logic [15:0] SPAN_256 = 16'h00ff;
  localparam logic [31:0] MEM_BIOS_TOP = 32'h000f_0000;
  localparam logic [31:0] MEM_BIOS_TOP_4G = 32'hffff_0000;
  localparam logic [31:0] MEM_BIOS_TOP_4G1M = 32'hffef_0000;
  localparam logic [31:0] MEM_BIOS_LOW = 32'h000e_0000;
  localparam logic [31:0] MEM_BIOS_LOW_4G = 32'hfffe_0000;
  localparam logic [31:0] MEM_BIOS_LOW_4G1M = 32'hffee_0000;
  localparam logic [31:0] MEM_BIOS_EXT = 32'hfff8_0000;
  localparam logic [31:0] MEM_SPAN_64K = 32'h0000_ffff;
  localparam logic [31:0] MEM_SPAN_384K = 32'h0005_ffff;
  typedef enum logic [2:0] {
    UBCSD_FPU_IDLE = 3'b001,
    UBCSD_FPU_PEND = 3'b010,
    UBCSD_FPU_IGNORE = 3'b100
  } ubcsd_fpu_state_t;
endpackage

// [logic/ubcsd_top.sv]
// utility-bus chip select decode, alternate_system_control, disk change and coprocessor error logic
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ubcsd_top
  import ubcsd_pkg::*;
#(
  parameter bit KBD_FOUR_PORTS = 1'b1,
  parameter bit RESET_HOLD_LOW = 1'b1
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [31:0] cyc_addr_in,
  input wire logic cyc_io_rd_in,
  input wire logic cyc_io_wr_in,
  input wire logic cyc_mem_rd_in,
  input wire logic cyc_mem_wr_in,
  input wire logic disk_change_in,
  input wire logic fpu_error_n_in,
  output logic encoded_select_bit2_out,
  output logic encoded_select_bit1_out,
  output logic encoded_select_bit0_out,
  output logic decoder_group_select_n_out,
  output logic utility_buffer_oe_n_out,
  output logic utility_buffer_direction_out,
  output logic sys_data_bit7_out,
  output logic sys_data_bit7_oe_out,
  output logic alternate_reset_out,
  output logic alternate_gate_a20_out,
  output logic fpu_irq_out,
  output logic ignore_fpu_error_n_out
);

  function automatic logic in_io(input logic [15:0] a, input logic [15:0] base,
                                 input logic [15:0] span);
    in_io = (a >= base) && (a <= (base | span));
  endfunction

  function automatic logic in_mem(input logic [31:0] a, input logic [31:0] base,
                                  input logic [31:0] span);
    in_mem = (a >= base) && (a <= (base | span));
  endfunction

  logic [7:0] alt_ctrl_r, alt_ctrl_nxt;
  logic [7:0] dec_en_r, dec_en_nxt;
  logic [7:0] dec_sel_r, dec_sel_nxt;
  logic [7:0] clk_div_r, clk_div_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic buf_oe_n_r, buf_oe_n_nxt;
  logic buf_dir_r, buf_dir_nxt;
  logic sd7_r, sd7_nxt;
  logic sd7_oe_r, sd7_oe_nxt;
  ubcsd_fpu_state_t fpu_r, fpu_nxt;

  logic [15:0] io_a;
  logic io_cyc;
  logic mem_cyc;
  logic fpu_clear_hit;
  logic fpu_mode;
  logic fpu_err;

  assign io_a = cyc_addr_in[15:0];
  assign io_cyc = cyc_io_rd_in | cyc_io_wr_in;
  assign mem_cyc = cyc_mem_rd_in | cyc_mem_wr_in;
  assign fpu_mode = clk_div_r[FPU_MODE_BIT];
  assign fpu_err = ~fpu_error_n_in;
  // the clear may arrive from the register port or as a system i/o write
  assign fpu_clear_hit = (reg_wr_in && (reg_addr_in == ADDR_FPU_CLEAR)) ||
                         (cyc_io_wr_in && (io_a == IO_FPU_CLEAR));

  // register port: writes and one-cycle-late read data
  always_comb
  begin
    alt_ctrl_nxt = alt_ctrl_r;
    dec_en_nxt = dec_en_r;
    dec_sel_nxt = dec_sel_r;
    clk_div_nxt = clk_div_r;
    rdata_nxt = RESET_BYTE;
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        ADDR_ALT_SYS_CTRL: alt_ctrl_nxt = reg_wdata_in;
        ADDR_DECODE_ENABLE: dec_en_nxt = reg_wdata_in;
        ADDR_DECODE_SELECT: dec_sel_nxt = reg_wdata_in;
        ADDR_ISA_CLOCK_DIV: clk_div_nxt = reg_wdata_in;
        default: alt_ctrl_nxt = alt_ctrl_r;
      endcase
    end
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        ADDR_ALT_SYS_CTRL: rdata_nxt = alt_ctrl_r;
        ADDR_DECODE_ENABLE: rdata_nxt = dec_en_r;
        ADDR_DECODE_SELECT: rdata_nxt = dec_sel_r;
        ADDR_ISA_CLOCK_DIV: rdata_nxt = clk_div_r;
        default: rdata_nxt = RESET_BYTE;
      endcase
    end
  end

  // reset wins over the clock enable so the block always comes up idle
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      alt_ctrl_r <= RESET_BYTE;
      dec_en_r <= RESET_BYTE;
      dec_sel_r <= RESET_BYTE;
      clk_div_r <= RESET_BYTE;
      rdata_r <= RESET_BYTE;
    end
    else if (ce_in)
    begin
      alt_ctrl_r <= alt_ctrl_nxt;
      dec_en_r <= dec_en_nxt;
      dec_sel_r <= dec_sel_nxt;
      clk_div_r <= clk_div_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // address decode into group and code; first match wins
  always_comb
  begin
    logic sec;
    logic [15:0] prn_base;
    logic disk_change_hit;
    sec = dec_en_r[EN_SECONDARY_BIT];
    prn_base = IO_PRINTER_1;
    disk_change_hit = 1'b0;
    sel_nxt = SEL_IDLE;
    buf_oe_n_nxt = 1'b1;
    buf_dir_nxt = 1'b0;
    sd7_nxt = 1'b0;
    sd7_oe_nxt = 1'b0;
    // printer code 3 leaves the port undecoded
    unique case (dec_sel_r[SEL_PRINTER_LSB +: 2])
      PRN_RANGE2: prn_base = IO_PRINTER_2;
      PRN_RANGE3: prn_base = IO_PRINTER_3;
      default: prn_base = IO_PRINTER_1;
    endcase
    if (io_cyc)
    begin
      // clock chip strobe on even writes, select on odd
      if (in_io(io_a, IO_CLOCK_LO, SPAN_8) && !io_a[0] && cyc_io_wr_in)
        sel_nxt = SEL_CLOCK_STROBE;
      else if (in_io(io_a, IO_CLOCK_LO, SPAN_8) && io_a[0] && (io_a <= IO_CLOCK_HI))
        sel_nxt = SEL_CLOCK_CHIP;
      // keyboard ports, two or four depending on variant
      else if ((io_a == IO_KBD_A) || (io_a == IO_KBD_C) ||
               (KBD_FOUR_PORTS && ((io_a == IO_KBD_B) || (io_a == IO_KBD_D))))
        sel_nxt = SEL_KEYBOARD;
      // disk selects take 3f6/3f7 ahead of floppy
      else if (dec_en_r[EN_DISK_BIT] &&
               in_io(io_a, sec ? IO_DISK1_SEC : IO_DISK1_PRI, SPAN_2))
        sel_nxt = SEL_DISK1;
      else if (dec_en_r[EN_DISK_BIT] &&
               in_io(io_a, sec ? IO_DISK0_SEC : IO_DISK0_PRI, SPAN_8))
        sel_nxt = SEL_DISK0;
      else if (dec_en_r[EN_FLOPPY_BIT] &&
               in_io(io_a, sec ? IO_FLOPPY_SEC : IO_FLOPPY_PRI, SPAN_8))
        sel_nxt = SEL_FLOPPY;
      else if (io_a == IO_CONFIG_PAGE)
        sel_nxt = SEL_CONFIG_PAGE;
      else if (in_io(io_a, IO_CONFIG_MEM, SPAN_256))
        sel_nxt = SEL_CONFIG_MEM;
      // serial ports; port a wins if both share a range
      else if (dec_en_r[EN_SERIAL_A_BIT] &&
               in_io(io_a, dec_sel_r[SEL_SERIAL_A_BIT] ? IO_SERIAL_2 : IO_SERIAL_1, SPAN_8))
        sel_nxt = SEL_SERIAL_A;
      else if (dec_en_r[EN_SERIAL_B_BIT] &&
               in_io(io_a, dec_sel_r[SEL_SERIAL_B_BIT] ? IO_SERIAL_2 : IO_SERIAL_1, SPAN_8))
        sel_nxt = SEL_SERIAL_B;
      else if (dec_en_r[EN_PRINTER_BIT] && (dec_sel_r[SEL_PRINTER_LSB +: 2] != 2'h3) &&
               in_io(io_a, prn_base, (prn_base == IO_PRINTER_1) ? SPAN_4 : SPAN_8))
        sel_nxt = SEL_PRINTER;
      // disk change read only in floppy-only mode
      disk_change_hit = cyc_io_rd_in && dec_en_r[EN_FLOPPY_BIT] && !dec_en_r[EN_DISK_BIT] &&
                   (io_a == (sec ? IO_DISK_CHANGE_SEC : IO_DISK_CHANGE_PRI));
    end
    else if (mem_cyc)
    begin
      // top 64k and its high aliases
      if (in_mem(cyc_addr_in, MEM_BIOS_TOP, MEM_SPAN_64K) ||
          in_mem(cyc_addr_in, MEM_BIOS_TOP_4G, MEM_SPAN_64K) ||
          in_mem(cyc_addr_in, MEM_BIOS_TOP_4G1M, MEM_SPAN_64K))
        sel_nxt = SEL_BOOT_ROM;
      // lower 64k and aliases when enabled
      else if (dec_en_r[EN_BIOS_LOW_BIT] &&
               (in_mem(cyc_addr_in, MEM_BIOS_LOW, MEM_SPAN_64K) ||
                in_mem(cyc_addr_in, MEM_BIOS_LOW_4G, MEM_SPAN_64K) ||
                in_mem(cyc_addr_in, MEM_BIOS_LOW_4G1M, MEM_SPAN_64K)))
        sel_nxt = SEL_BOOT_ROM;
      // extra 384k below the top aliases
      else if (dec_en_r[EN_BIOS_EXT_BIT] &&
               in_mem(cyc_addr_in, MEM_BIOS_EXT, MEM_SPAN_384K))
        sel_nxt = SEL_BOOT_ROM;
    end
    if (disk_change_hit)
    begin
      sd7_nxt = ~disk_change_in;
      sd7_oe_nxt = 1'b1;
    end
    // buffer on for any selected peripheral, pointing to the system on reads
    // the buffer stays off while the block itself drives bit 7
    if ((sel_nxt != SEL_IDLE) && !disk_change_hit)
    begin
      buf_oe_n_nxt = 1'b0;
      buf_dir_nxt = cyc_io_rd_in | cyc_mem_rd_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sel_r <= SEL_IDLE;
      buf_oe_n_r <= 1'b1;
      buf_dir_r <= 1'b0;
      sd7_r <= 1'b0;
      sd7_oe_r <= 1'b0;
    end
    else if (ce_in)
    begin
      sel_r <= sel_nxt;
      buf_oe_n_r <= buf_oe_n_nxt;
      buf_dir_r <= buf_dir_nxt;
      sd7_r <= sd7_nxt;
      sd7_oe_r <= sd7_oe_nxt;
    end
  end

  // coprocessor error sequence
  always_comb
  begin
    fpu_nxt = fpu_r;
    unique case (fpu_r)
      UBCSD_FPU_IDLE:
      begin
        // error raises request only in error mode
        if (fpu_mode && fpu_err)
          fpu_nxt = UBCSD_FPU_PEND;
      end
      UBCSD_FPU_PEND:
      begin
        // clear request, go ignore while error still active
        if (!fpu_mode)
          fpu_nxt = UBCSD_FPU_IDLE;
        else if (fpu_clear_hit)
          fpu_nxt = fpu_err ? UBCSD_FPU_IGNORE : UBCSD_FPU_IDLE;
      end
      UBCSD_FPU_IGNORE:
      begin
        // release ignore once the error goes away
        if (!fpu_err || !fpu_mode)
          fpu_nxt = UBCSD_FPU_IDLE;
      end
      default: fpu_nxt = UBCSD_FPU_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      fpu_r <= UBCSD_FPU_IDLE;
    else if (ce_in)
      fpu_r <= fpu_nxt;
  end

  // read data is zero after every clock-enabled cycle with no read strobe, and holds while the clock enable is low
  assign reg_rdata_out = rdata_r;
  assign decoder_group_select_n_out = sel_r[3];
  assign encoded_select_bit2_out = sel_r[2];
  assign encoded_select_bit1_out = sel_r[1];
  assign encoded_select_bit0_out = sel_r[0];
  // outside logic handles the disk-only buffer case
  assign utility_buffer_oe_n_out = buf_oe_n_r;
  assign utility_buffer_direction_out = buf_dir_r;
  assign sys_data_bit7_out = sd7_r;
  assign sys_data_bit7_oe_out = sd7_oe_r;
  assign alternate_reset_out = alt_ctrl_r[ALT_RESET_BIT];
  // cpu-side lines forced low while reset is high; gated so no glitch reaches the cpu
  assign alternate_gate_a20_out = (RESET_HOLD_LOW && reset_in) ? 1'b0 : alt_ctrl_r[ALTERNATE_GATE_A20_BIT];
  assign fpu_irq_out = (RESET_HOLD_LOW && reset_in) ? 1'b0 : (fpu_r == UBCSD_FPU_PEND);
  // ignore never active without the error, except while reset holds it low
  assign ignore_fpu_error_n_out = (RESET_HOLD_LOW && reset_in) ? 1'b0 :
                                  !((fpu_r == UBCSD_FPU_IGNORE) && fpu_err);

endmodule
`default_nettype wire

// [testbench/ubcsd_properties.sv]
// port-level checker for the utility-bus decode block
`timescale 1ns/1ps
`default_nettype none
module ubcsd_properties
  import ubcsd_pkg::*;
#(
  parameter bit RESET_HOLD_LOW = 1'b1
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [31:0] cyc_addr_in,
  input wire logic cyc_io_rd_in,
  input wire logic cyc_io_wr_in,
  input wire logic cyc_mem_rd_in,
  input wire logic cyc_mem_wr_in,
  input wire logic disk_change_in,
  input wire logic fpu_error_n_in,
  input wire logic encoded_select_bit2_out,
  input wire logic encoded_select_bit1_out,
  input wire logic encoded_select_bit0_out,
  input wire logic decoder_group_select_n_out,
  input wire logic utility_buffer_oe_n_out,
  input wire logic utility_buffer_direction_out,
  input wire logic sys_data_bit7_out,
  input wire logic sys_data_bit7_oe_out,
  input wire logic alternate_reset_out,
  input wire logic alternate_gate_a20_out,
  input wire logic fpu_irq_out,
  input wire logic ignore_fpu_error_n_out
);
  logic [3:0] sel;
  logic io_rd;
  logic mem_rd;
  logic wr_rst;
  logic wr_a20;
  logic mode_r;
  assign sel = {decoder_group_select_n_out, encoded_select_bit2_out,
    encoded_select_bit1_out, encoded_select_bit0_out};
  assign io_rd = ce_in && cyc_io_rd_in && !cyc_io_wr_in && !cyc_mem_rd_in && !cyc_mem_wr_in;
  assign mem_rd = ce_in && cyc_mem_rd_in && !cyc_io_rd_in && !cyc_io_wr_in;
  assign wr_rst = reg_wdata_in[ALT_RESET_BIT];
  assign wr_a20 = reg_wdata_in[ALTERNATE_GATE_A20_BIT];
  // shadow of the error-mode bit, the only register state the checker needs
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      mode_r <= 1'b0;
    else if (ce_in && reg_wr_in && reg_addr_in == ADDR_ISA_CLOCK_DIV)
      mode_r <= reg_wdata_in[FPU_MODE_BIT];
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_IDLE_IN_RESET: assert property (disable iff (1'b0) reset_in |=> sel == SEL_IDLE)
    else $error("select not idle after reset");
  AST_NO_CYCLE_IDLE: assert property (ce_in && !cyc_io_rd_in && !cyc_io_wr_in
    && !cyc_mem_rd_in && !cyc_mem_wr_in |=> sel == SEL_IDLE)
    else $error("select not idle without a cycle");
  AST_KEYBOARD_READ: assert property (io_rd && cyc_addr_in[15:0] == IO_KBD_C |=>
    sel == SEL_KEYBOARD && !utility_buffer_oe_n_out && utility_buffer_direction_out)
    else $error("keyboard read decode or buffer control wrong");
  AST_BOOT_TOP: assert property (mem_rd && (cyc_addr_in[31:16] == 16'h000f
    || cyc_addr_in[31:16] == 16'hffff || cyc_addr_in[31:16] == 16'hffef) |=> sel == SEL_BOOT_ROM)
    else $error("top boot region not selected");
  AST_CONFIG_PAGE: assert property (io_rd && cyc_addr_in[15:0] == IO_CONFIG_PAGE
    |=> sel == SEL_CONFIG_PAGE)
    else $error("config page not selected");
  AST_DISK_CHANGE: assert property (sys_data_bit7_oe_out && $past(ce_in) |->
    sys_data_bit7_out == !$past(disk_change_in) && utility_buffer_oe_n_out)
    else $error("data bit 7 not inverted disk change");
  AST_IGNORE_NEEDS_ERROR: assert property (fpu_error_n_in |-> ignore_fpu_error_n_out)
    else $error("ignore asserted without error");
  AST_IRQ_CAUSE: assert property ($rose(fpu_irq_out) |-> $past(mode_r) && !$past(fpu_error_n_in))
    else $error("interrupt raised without error in error mode");
  AST_CLEAR_WRITE: assert property (ce_in && reg_wr_in && reg_addr_in == ADDR_FPU_CLEAR
    && fpu_irq_out && !fpu_error_n_in |=> !fpu_irq_out && ignore_fpu_error_n_out == fpu_error_n_in)
    else $error("clear write did not drop interrupt and set ignore");
  AST_PORT92_WRITE: assert property (ce_in && reg_wr_in && reg_addr_in == ADDR_ALT_SYS_CTRL |=>
    alternate_reset_out == $past(wr_rst) && alternate_gate_a20_out == $past(wr_a20))
    else $error("alternate outputs do not follow write");
  AST_RESET_LOW: assert property (disable iff (1'b0) reset_in |-> !alternate_gate_a20_out
    && !fpu_irq_out && ignore_fpu_error_n_out == !RESET_HOLD_LOW)
    else $error("cpu outputs not held during reset");
endmodule
bind ubcsd_top ubcsd_properties #(.RESET_HOLD_LOW(RESET_HOLD_LOW)) i_props (.*);
`default_nettype wire

// [testbench/ubcsd_partner.sv]
// external decoders, transceiver gating and data bit 7 wire
`timescale 1ns/1ps
`default_nettype none
module ubcsd_partner
(
  input wire logic clk_in,
  input wire logic [3:0] sel_in,
  input wire logic oe_n_in,
  input wire logic disk_only_in,
  input wire logic [15:0] io_addr_in,
  input wire logic sd7_in,
  input wire logic sd7_oe_in,
  output logic [15:0] periph_sel_n_out,
  output logic buffer_on_out,
  output logic sd7_wire_out
);
  logic float_r = 1'b0;
  always_comb
  begin
    periph_sel_n_out = 16'hffff;
    if (sel_in != 4'hf)
      periph_sel_n_out[sel_in] = 1'b0;
  end
  assign buffer_on_out = !oe_n_in && !(disk_only_in
    && (io_addr_in == 16'h03f7 || io_addr_in == 16'h0377));
  // a released line toggles so a stale value never passes
  always_ff @(posedge clk_in)
    float_r <= !float_r;
  assign sd7_wire_out = sd7_oe_in ? sd7_in : float_r;
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the utility-bus decode block
`timescale 1ns/1ps
`default_nettype none
module tb
  import ubcsd_pkg::*;
;
  logic clk_in = 0, reset_in = 1, ce_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic [15:0] reg_addr_in = 0;
  logic [7:0] reg_wdata_in = 0, reg_rdata_out, d;
  logic [31:0] cyc_addr_in = 0;
  logic cyc_io_rd_in = 0, cyc_io_wr_in = 0, cyc_mem_rd_in = 0, cyc_mem_wr_in = 0;
  logic disk_change_in = 0, fpu_error_n_in = 1, disk_only = 0;
  logic encoded_select_bit2_out, encoded_select_bit1_out, encoded_select_bit0_out;
  logic decoder_group_select_n_out, utility_buffer_oe_n_out, utility_buffer_direction_out;
  logic sys_data_bit7_out, sys_data_bit7_oe_out, alternate_reset_out, alternate_gate_a20_out;
  logic fpu_irq_out, ignore_fpu_error_n_out, buffer_on, sd7_wire;
  logic [15:0] periph_sel_n;
  logic [3:0] sel;
  localparam logic [3:0] IOR = 4'h8, IOW = 4'h4, MR = 4'h2, MW = 4'h1;
  int mismatches = 0, checks = 0, cycles = 0;
  assign sel = {decoder_group_select_n_out, encoded_select_bit2_out,
    encoded_select_bit1_out, encoded_select_bit0_out};
  ubcsd_top i_dut (.*);
  ubcsd_partner i_far (.clk_in(clk_in), .sel_in(sel), .oe_n_in(utility_buffer_oe_n_out),
    .disk_only_in(disk_only), .io_addr_in(cyc_addr_in[15:0]), .sd7_in(sys_data_bit7_out),
    .sd7_oe_in(sys_data_bit7_oe_out), .periph_sel_n_out(periph_sel_n),
    .buffer_on_out(buffer_on), .sd7_wire_out(sd7_wire));
  always #2.5 clk_in = !clk_in;
  task report_and_stop;
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // one system cycle, then the select it produced
  task cyc(input logic [31:0] a, input logic [3:0] k, input logic [3:0] exp);
    @(posedge clk_in);
    cyc_addr_in <= a;
    {cyc_io_rd_in, cyc_io_wr_in, cyc_mem_rd_in, cyc_mem_wr_in} <= k;
    @(posedge clk_in);
    {cyc_io_rd_in, cyc_io_wr_in, cyc_mem_rd_in, cyc_mem_wr_in} <= 4'h0;
    #1 chk(sel, exp);
  endtask
  task t_fixed;
    int i;
    cyc(16'h0070, IOW, SEL_CLOCK_STROBE);
    cyc(16'h0070, IOR, SEL_IDLE);
    cyc(16'h0077, IOR, SEL_CLOCK_CHIP);
    for (i = 0; i < 4; i++)
      cyc(16'h0060 + 2 * i, IOR, SEL_KEYBOARD);
    chk({utility_buffer_oe_n_out, utility_buffer_direction_out, periph_sel_n[2]}, 3'h2);
    cyc(16'h0066, IOW, SEL_KEYBOARD);
    chk({utility_buffer_oe_n_out, utility_buffer_direction_out}, 2'h0);
    cyc(16'h0c00, IOR, SEL_CONFIG_PAGE);
    cyc(16'h08ff, IOW, SEL_CONFIG_MEM);
    cyc(16'h0900, IOR, SEL_IDLE);
    cyc(16'h0064, 4'h0, SEL_IDLE);
  endtask
  task t_boot;
    cyc(32'h000f_1234, MR, SEL_BOOT_ROM);
    cyc(32'hffff_fff0, MW, SEL_BOOT_ROM);
    cyc(32'hffef_0000, MR, SEL_BOOT_ROM);
    cyc(32'h000e_8000, MR, SEL_IDLE);
    wr(ADDR_DECODE_ENABLE, 8'h08);
    cyc(32'hfffe_0000, MR, SEL_BOOT_ROM);
    cyc(32'hffee_ffff, MR, SEL_BOOT_ROM);
    cyc(32'hfffd_0000, MR, SEL_IDLE);
    wr(ADDR_DECODE_ENABLE, 8'h18);
    cyc(32'hfffd_ffff, MR, SEL_BOOT_ROM);
    cyc(32'hfff8_0000, MW, SEL_BOOT_ROM);
  endtask
  task t_disk;
    wr(ADDR_DECODE_ENABLE, 8'h03);
    cyc(16'h03f0, IOR, SEL_FLOPPY);
    cyc(16'h01f7, IOW, SEL_DISK0);
    cyc(16'h03f6, IOR, SEL_DISK1);
    cyc(16'h0370, IOR, SEL_IDLE);
    wr(ADDR_DECODE_ENABLE, 8'h07);
    cyc(16'h0376, IOR, SEL_DISK1);
    cyc(16'h0170, IOW, SEL_DISK0);
    cyc(16'h0375, IOR, SEL_FLOPPY);
    cyc(16'h03f0, IOR, SEL_IDLE);
  endtask
  task t_disk_change;
    wr(ADDR_DECODE_ENABLE, 8'h01);
    disk_change_in <= 1'b1;
    cyc(16'h03f7, IOR, SEL_FLOPPY);
    chk({sys_data_bit7_oe_out, sd7_wire, utility_buffer_oe_n_out}, 3'h5);
    wr(ADDR_DECODE_ENABLE, 8'h05);
    disk_change_in <= 1'b0;
    cyc(16'h0377, IOR, SEL_FLOPPY);
    chk({sys_data_bit7_oe_out, sd7_wire}, 2'h3);
    wr(ADDR_DECODE_ENABLE, 8'h03);
    cyc(16'h03f7, IOR, SEL_DISK1);
    chk({sys_data_bit7_oe_out, utility_buffer_oe_n_out}, 2'h0);
    wr(ADDR_DECODE_ENABLE, 8'h02);
    disk_only <= 1'b1;
    cyc(16'h03f7, IOR, SEL_DISK1);
    chk({sys_data_bit7_oe_out, utility_buffer_oe_n_out, buffer_on}, 3'h0);
    disk_only <= 1'b0;
  endtask
  task t_ports;
    wr(ADDR_DECODE_ENABLE, 8'he0);
    wr(ADDR_DECODE_SELECT, 8'h02);
    cyc(16'h03ff, IOR, SEL_SERIAL_A);
    cyc(16'h02f8, IOW, SEL_SERIAL_B);
    cyc(16'h03bc, IOR, SEL_PRINTER);
    wr(ADDR_DECODE_SELECT, 8'h05);
    cyc(16'h02ff, IOR, SEL_SERIAL_A);
    cyc(16'h03f8, IOR, SEL_SERIAL_B);
    cyc(16'h037f, IOW, SEL_PRINTER);
    cyc(16'h03bc, IOR, SEL_IDLE);
    wr(ADDR_DECODE_SELECT, 8'h08);
    cyc(16'h0278, IOR, SEL_PRINTER);
    cyc(16'h0378, IOR, SEL_IDLE);
    wr(ADDR_DECODE_SELECT, 8'h0c);
    cyc(16'h0278, IOR, SEL_IDLE);
  endtask
  task t_port92;
    wr(ADDR_ALT_SYS_CTRL, 8'h03);
    rd(ADDR_ALT_SYS_CTRL);
    chk({d, alternate_reset_out, alternate_gate_a20_out}, 10'h00f);
    @(posedge clk_in);
    #1 chk(reg_rdata_out, RESET_BYTE);
    wr(ADDR_ALT_SYS_CTRL, 8'h02);
    rd(ADDR_ALT_SYS_CTRL);
    chk({d, alternate_reset_out, alternate_gate_a20_out}, 10'h009);
    // a write while the clock enable is low must not land
    @(posedge clk_in) ce_in <= 1'b0;
    wr(ADDR_ALT_SYS_CTRL, 8'h01);
    ce_in <= 1'b1;
    rd(ADDR_ALT_SYS_CTRL);
    chk({d, alternate_reset_out, alternate_gate_a20_out}, 10'h009);
  endtask
  task t_fpu;
    wr(ADDR_ISA_CLOCK_DIV, 8'h00);
    fpu_error_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 chk({fpu_irq_out, ignore_fpu_error_n_out}, 2'h1);
    wr(ADDR_ISA_CLOCK_DIV, 8'h20);
    @(posedge clk_in);
    #1 chk({fpu_irq_out, ignore_fpu_error_n_out}, 2'h3);
    wr(ADDR_FPU_CLEAR, 8'h00);
    #1 chk({fpu_irq_out, ignore_fpu_error_n_out}, 2'h0);
    @(posedge clk_in) fpu_error_n_in <= 1'b1;
    #1 chk(ignore_fpu_error_n_out, 1'b1);
    @(posedge clk_in) fpu_error_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk(fpu_irq_out, 1'b1);
    cyc(16'h00f0, IOW, SEL_IDLE);
    chk({fpu_irq_out, ignore_fpu_error_n_out}, 2'h0);
    @(posedge clk_in) fpu_error_n_in <= 1'b1;
    @(posedge clk_in) fpu_error_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b1;
    #1 chk({alternate_gate_a20_out, fpu_irq_out, ignore_fpu_error_n_out}, 3'h0);
    @(posedge clk_in) reset_in <= 1'b0;
    #1 chk(sel, SEL_IDLE);
    @(posedge clk_in);
    #1 chk({fpu_irq_out, alternate_gate_a20_out, ignore_fpu_error_n_out}, 3'h1);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    #1 chk(sel, SEL_IDLE);
    rd(ADDR_ALT_SYS_CTRL);
    chk(d, RESET_BYTE);
    rd(16'h0055);
    chk(d, 8'h00);
    t_fixed();
    t_boot();
    t_disk();
    t_disk_change();
    t_ports();
    t_port92();
    t_fpu();
    report_and_stop();
  end
endmodule
`default_nettype wire
